/* File: cpu8d_pkg.sv */
`default_nettype none
package cpu8d_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_COUNT   = 8'h08;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam int          CTRL_EN_BIT  = 0;
  // ---------------------------------------------------------------
  // instruction lengths and cycle counts
  // ---------------------------------------------------------------
  localparam logic [1:0]  LEN_ONE      = 2'h1;
  localparam logic [1:0]  LEN_TWO      = 2'h2;
  localparam logic [1:0]  LEN_THREE    = 2'h3;
  localparam logic [3:0]  CYC_TWO      = 4'h2;
  localparam logic [3:0]  CYC_BRANCH   = 4'h3;
  localparam logic [3:0]  CYC_SUBR     = 4'h6;
  localparam logic [3:0]  CYC_BIT      = 4'h5;
  localparam logic [3:0]  CYC_RMW_REG  = 4'h3;
  localparam logic [3:0]  CYC_RMW_DIR  = 4'h5;
  localparam logic [3:0]  CYC_RMW_IX0  = 4'h5;
  localparam logic [3:0]  CYC_RMW_IX1  = 4'h6;
  localparam logic [3:0]  CYC_MUL      = 4'hB;
  localparam logic [3:0]  CYC_TRAP     = 4'hA;
  localparam logic [3:0]  CYC_RTS      = 4'h6;
  localparam logic [3:0]  CYC_RETI     = 4'h9;
  localparam logic [3:0]  CYC_DIR      = 4'h3;
  localparam logic [3:0]  CYC_DIR_ST   = 4'h4;
  localparam logic [3:0]  CYC_DIR_JSR  = 4'h5;
  localparam logic [7:0]  OP_SUBR      = 8'hAD;
  localparam logic [7:0]  ZERO_PAGE    = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_REL, MODE_IX0, MODE_IX1,
    MODE_BSC, MODE_BTB, MODE_OTHER
  } cpu8d_mode_t;

  typedef enum logic [3:0] {
    RMW_NONE, RMW_NEGATE, RMW_COM, RMW_SHR, RMW_ROTR, RMW_SAR, RMW_SHL,
    RMW_ROTL, RMW_DECR, RMW_INC, RMW_TEST, RMW_ZERO, RMW_MUL
  } cpu8d_rmw_t;

  typedef enum logic [3:0] {
    CTL_NONE, CTL_A2X, CTL_X2A, CTL_SETC, CTL_CLRC, CTL_SETI, CTL_CLRI,
    CTL_TRAP, CTL_RTS, CTL_RETI, CTL_SPRST, CTL_IDLE, CTL_STOP, CTL_WAIT
  } cpu8d_ctl_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cpu8d_flags_t;

  typedef struct packed {
    cpu8d_mode_t mode;
    logic [1:0]  length;
    logic [3:0]  cycles;
    cpu8d_rmw_t  rmw_op;
    cpu8d_ctl_t  ctl_op;
    logic [2:0]  bit_n;
    logic        on_index;
    logic        is_branch;
    logic        taken;
    logic        mem_read;
    logic        mem_write;
    logic        illegal;
    logic [15:0] effective_addr;
    logic [15:0] next_pc;
    logic [7:0]  result;
    logic        carry_out;
  } cpu8d_dec_t;
endpackage
`default_nettype wire

/* File: cpu8d_decode.sv */
// Notes on behaviour
// (RL1) inherent: opcode only, one byte
// (RL2) immediate: operand at PC+1, PC+2
// (RL3) direct: high byte zero, PC+2
// (RL4) 22 higher, 23 lower or same
// (RL5) 24 carry clear, 25 carry set
// (RL6) other relative conditions; two bytes, three cycles
// (RL7) 2C mask clear, 2D mask set
// (RL8) 2E line low, 2F line high
// (RL9) AD subroutine branch, two bytes, six cycles
// (RL10) bit test branch: 3 bytes, 5 cycles
// (RL11) bit set/clear: 2 bytes, 5 cycles
// (RL12) low nibble picks modify operation
// (RL13) high nibble picks operand or mode
// (RL14) modify timing; memory test one less
// (RL15) carry and mask flag ops, two cycles
// (RL16) trap 10, return sub 6, interrupt 9
// (RL17) transfers, stack reset, no-op: two cycles
// (RL18) 8E stop, 8F wait, two cycles
// (RL19) taken branch adds signed offset
// (RL20) memory modify reads, writes back; test reads
`default_nettype none
module cpu8d_decode (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // decode request from fetch
  input  wire logic                  dec_valid_i,
  input  wire logic [7:0]            opcode_i,
  input  wire logic [7:0]            operand1_i,
  input  wire logic [7:0]            operand2_i,
  input  wire logic [15:0]           pc_i,
  input  wire logic [7:0]            index_i,
  input  wire logic [7:0]            data_byte_i,
  input  wire cpu8d_pkg::cpu8d_flags_t flags_i,
  // external interrupt pin
  input  wire logic                  irq_line_i,
  // decode answer
  output logic                       dec_valid_o,
  output cpu8d_pkg::cpu8d_dec_t      dec_o
);
  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic irq_meta_ff;
  logic irq_sync_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_meta_ff <= 1'b1;
      irq_sync_ff <= 1'b1;
    end else begin
      irq_meta_ff <= irq_line_i;
      irq_sync_ff <= irq_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // modify unit
  // ---------------------------------------------------------------
  logic [7:0] alu_res;
  logic       alu_c;
  always_comb begin
    alu_res = data_byte_i;
    alu_c   = flags_i.c;
    case (opcode_i[3:0])
      4'h0: begin
        alu_res = 8'h00 - data_byte_i;
        alu_c   = |data_byte_i;
      end
      4'h3: begin
        alu_res = ~data_byte_i;
        alu_c   = 1'b1;
      end
      4'h4: begin
        alu_res = {1'b0, data_byte_i[7:1]};
        alu_c   = data_byte_i[0];
      end
      4'h6: begin
        alu_res = {flags_i.c, data_byte_i[7:1]};
        alu_c   = data_byte_i[0];
      end
      4'h7: begin
        alu_res = {data_byte_i[7], data_byte_i[7:1]};
        alu_c   = data_byte_i[0];
      end
      4'h8: begin
        alu_res = {data_byte_i[6:0], 1'b0};
        alu_c   = data_byte_i[7];
      end
      4'h9: begin
        alu_res = {data_byte_i[6:0], flags_i.c};
        alu_c   = data_byte_i[7];
      end
      4'hA:    alu_res = data_byte_i - 8'h01;
      4'hC:    alu_res = data_byte_i + 8'h01;
      4'hF:    alu_res = 8'h00;
      default: alu_res = data_byte_i;
    endcase
  end

  // ---------------------------------------------------------------
  // branch condition: even codes test, odd codes invert
  // ---------------------------------------------------------------
  logic cond_base;
  logic cond;
  always_comb begin
    case (opcode_i[3:1])
      3'h0: cond_base = 1'b1;                       // [RL6]
      3'h1: cond_base = ~(flags_i.c | flags_i.z);   // [RL4]
      3'h2: cond_base = ~flags_i.c;                 // [RL5]
      3'h3: cond_base = ~flags_i.z;                 // [RL6]
      3'h4: cond_base = ~flags_i.h;                 // [RL6]
      3'h5: cond_base = ~flags_i.n;                 // [RL6]
      3'h6: cond_base = ~flags_i.i;                 // [RL7]
      default: cond_base = ~irq_sync_ff;            // [RL8]
    endcase
    cond = cond_base ^ opcode_i[0];
  end

  // ---------------------------------------------------------------
  // opcode decode
  // ---------------------------------------------------------------
  cpu8d_pkg::cpu8d_dec_t d;
  logic [7:0]            offset;
  logic [15:0]           seq_pc;
  always_comb begin
    d        = '0;
    d.mode   = cpu8d_pkg::MODE_INH;
    d.rmw_op = cpu8d_pkg::RMW_NONE;
    d.ctl_op = cpu8d_pkg::CTL_NONE;
    d.length = cpu8d_pkg::LEN_ONE;
    d.cycles = cpu8d_pkg::CYC_TWO;
    offset   = operand1_i;
    d.bit_n  = opcode_i[3:1];
    case (opcode_i[7:4])
      4'h0: begin
        d.mode      = cpu8d_pkg::MODE_BTB;              // [RL10]
        d.length    = cpu8d_pkg::LEN_THREE;
        d.cycles    = cpu8d_pkg::CYC_BIT;
        d.mem_read  = 1'b1;
        d.is_branch = 1'b1;
        d.carry_out = data_byte_i[d.bit_n];
        d.taken     = data_byte_i[d.bit_n] ^ opcode_i[0];
        d.effective_addr = {cpu8d_pkg::ZERO_PAGE, operand1_i};
        offset      = operand2_i;
      end
      4'h1: begin
        d.mode      = cpu8d_pkg::MODE_BSC;              // [RL11]
        d.length    = cpu8d_pkg::LEN_TWO;
        d.cycles    = cpu8d_pkg::CYC_BIT;
        d.mem_read  = 1'b1;
        d.mem_write = 1'b1;
        d.result    = data_byte_i;
        d.result[d.bit_n] = ~opcode_i[0];
        d.effective_addr = {cpu8d_pkg::ZERO_PAGE, operand1_i};
      end
      4'h2: begin
        d.mode      = cpu8d_pkg::MODE_REL;              // [RL6]
        d.length    = cpu8d_pkg::LEN_TWO;
        d.cycles    = cpu8d_pkg::CYC_BRANCH;
        d.is_branch = 1'b1;
        d.taken     = cond;
      end
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        case (opcode_i[3:0])                            // [RL12]
          4'h0: d.rmw_op = cpu8d_pkg::RMW_NEGATE;
          4'h3: d.rmw_op = cpu8d_pkg::RMW_COM;
          4'h4: d.rmw_op = cpu8d_pkg::RMW_SHR;
          4'h6: d.rmw_op = cpu8d_pkg::RMW_ROTR;
          4'h7: d.rmw_op = cpu8d_pkg::RMW_SAR;
          4'h8: d.rmw_op = cpu8d_pkg::RMW_SHL;
          4'h9: d.rmw_op = cpu8d_pkg::RMW_ROTL;
          4'hA: d.rmw_op = cpu8d_pkg::RMW_DECR;
          4'hC: d.rmw_op = cpu8d_pkg::RMW_INC;
          4'hD: d.rmw_op = cpu8d_pkg::RMW_TEST;
          4'hF: d.rmw_op = cpu8d_pkg::RMW_ZERO;
          default: d.rmw_op = cpu8d_pkg::RMW_NONE;
        endcase
        d.result    = alu_res;
        d.carry_out = alu_c;
        case (opcode_i[7:4])                            // [RL13]
          4'h3: begin
            d.mode   = cpu8d_pkg::MODE_DIR;             // [RL3]
            d.length = cpu8d_pkg::LEN_TWO;
            d.cycles = cpu8d_pkg::CYC_RMW_DIR;          // [RL14]
            d.effective_addr = {cpu8d_pkg::ZERO_PAGE, operand1_i};
          end
          4'h7: begin
            d.mode   = cpu8d_pkg::MODE_IX0;
            d.cycles = cpu8d_pkg::CYC_RMW_IX0;          // [RL14]
            d.effective_addr = {cpu8d_pkg::ZERO_PAGE, index_i};
          end
          4'h6: begin
            d.mode   = cpu8d_pkg::MODE_IX1;
            d.length = cpu8d_pkg::LEN_TWO;
            d.cycles = cpu8d_pkg::CYC_RMW_IX1;          // [RL14]
            d.effective_addr = {8'h00, index_i} + {8'h00, operand1_i};
          end
          default: begin
            d.on_index = opcode_i[4];                   // [RL1]
            d.cycles   = cpu8d_pkg::CYC_RMW_REG;        // [RL14]
          end
        endcase
        if (d.mode != cpu8d_pkg::MODE_INH) begin
          d.mem_read  = 1'b1;                           // [RL20]
          d.mem_write = (d.rmw_op != cpu8d_pkg::RMW_TEST);
          if (d.rmw_op == cpu8d_pkg::RMW_TEST) begin
            d.cycles = d.cycles - 4'h1;                 // [RL14]
          end
        end
        if (opcode_i == 8'h42) begin
          d.rmw_op = cpu8d_pkg::RMW_MUL;
          d.cycles = cpu8d_pkg::CYC_MUL;
        end
        d.illegal = (d.rmw_op == cpu8d_pkg::RMW_NONE);
      end
      4'h8: begin
        case (opcode_i[3:0])                            // [RL16] [RL18]
          4'h0: begin
            d.ctl_op = cpu8d_pkg::CTL_RETI;
            d.cycles = cpu8d_pkg::CYC_RETI;
          end
          4'h1: begin
            d.ctl_op = cpu8d_pkg::CTL_RTS;
            d.cycles = cpu8d_pkg::CYC_RTS;
          end
          4'h3: begin
            d.ctl_op = cpu8d_pkg::CTL_TRAP;
            d.cycles = cpu8d_pkg::CYC_TRAP;
          end
          4'hE:    d.ctl_op = cpu8d_pkg::CTL_STOP;
          4'hF:    d.ctl_op = cpu8d_pkg::CTL_WAIT;
          default: d.illegal = 1'b1;
        endcase
      end
      4'h9: begin
        case (opcode_i[3:0])                            // [RL15] [RL17]
          4'h7:    d.ctl_op = cpu8d_pkg::CTL_A2X;
          4'h8:    d.ctl_op = cpu8d_pkg::CTL_CLRC;
          4'h9:    d.ctl_op = cpu8d_pkg::CTL_SETC;
          4'hA:    d.ctl_op = cpu8d_pkg::CTL_CLRI;
          4'hB:    d.ctl_op = cpu8d_pkg::CTL_SETI;
          4'hC:    d.ctl_op = cpu8d_pkg::CTL_SPRST;
          4'hD:    d.ctl_op = cpu8d_pkg::CTL_IDLE;
          4'hF:    d.ctl_op = cpu8d_pkg::CTL_X2A;
          default: d.illegal = 1'b1;
        endcase
      end
      4'hA: begin
        d.length = cpu8d_pkg::LEN_TWO;
        if (opcode_i == cpu8d_pkg::OP_SUBR) begin
          d.mode      = cpu8d_pkg::MODE_REL;            // [RL9]
          d.cycles    = cpu8d_pkg::CYC_SUBR;
          d.is_branch = 1'b1;
          d.taken     = 1'b1;
        end else begin
          d.mode     = cpu8d_pkg::MODE_IMM;             // [RL2]
          d.effective_addr = pc_i + 16'h0001;
          d.illegal  = (opcode_i[3:0] == 4'h7) || (opcode_i[3:0] >= 4'hC);
        end
      end
      4'hB: begin
        d.mode     = cpu8d_pkg::MODE_DIR;               // [RL3]
        d.length   = cpu8d_pkg::LEN_TWO;
        d.effective_addr = {cpu8d_pkg::ZERO_PAGE, operand1_i};
        d.cycles   = cpu8d_pkg::CYC_DIR;
        d.mem_read = (opcode_i[3:0] < 4'hC) && (opcode_i[2:0] != 3'h7);
        if (opcode_i[2:0] == 3'h7) begin
          d.cycles    = cpu8d_pkg::CYC_DIR_ST;
          d.mem_write = 1'b1;
        end
        if (opcode_i[3:0] == 4'hC) d.cycles = cpu8d_pkg::CYC_TWO;
        if (opcode_i[3:0] == 4'hD) d.cycles = cpu8d_pkg::CYC_DIR_JSR;
      end
      default: begin
        // wide modes are sequenced elsewhere; only the length is given
        d.mode   = cpu8d_pkg::MODE_OTHER;
        d.cycles = 4'h0;
        case (opcode_i[7:4])
          4'hC, 4'hD: d.length = cpu8d_pkg::LEN_THREE;
          4'hE:       d.length = cpu8d_pkg::LEN_TWO;
          default:    d.length = cpu8d_pkg::LEN_ONE;
        endcase
      end
    endcase
    seq_pc    = pc_i + {14'h0000, d.length};
    d.next_pc = d.taken ? seq_pc + {{8{offset[7]}}, offset} : seq_pc;  // [RL19]
  end

  // ---------------------------------------------------------------
  // decode output
  // ---------------------------------------------------------------
  logic [31:0]           ctrl_ff;
  logic                  dec_valid_ff;
  cpu8d_pkg::cpu8d_dec_t dec_ff;
  logic                  accept;
  assign accept = dec_valid_i & ctrl_ff[cpu8d_pkg::CTRL_EN_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_ff <= 1'b0;
      dec_ff       <= '0;
    end else begin
      dec_valid_ff <= accept;
      if (accept) dec_ff <= d;
    end
  end
  assign dec_valid_o = dec_valid_ff;
  assign dec_o       = dec_ff;

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [7:0]  last_op_ff;
  logic        illegal_ff;
  logic [31:0] count_ff;
  logic [31:0] prdata_ff;
  logic        mapped;
  logic        wr_done;
  assign mapped  = (paddr_i == cpu8d_pkg::ADDR_CTRL) || (paddr_i == cpu8d_pkg::ADDR_STATUS)
                 || (paddr_i == cpu8d_pkg::ADDR_COUNT);
  assign wr_done = psel_i & penable_i & pwrite_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= cpu8d_pkg::CTRL_RESET;
    end else if (wr_done && paddr_i == cpu8d_pkg::ADDR_CTRL) begin
      ctrl_ff <= {31'h0000_0000, pwdata_i[cpu8d_pkg::CTRL_EN_BIT]};
    end
  end

  // sticky illegal flag: a new illegal decode wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_op_ff <= 8'h00;
      illegal_ff <= 1'b0;
    end else begin
      if (accept) last_op_ff <= opcode_i;
      if (accept && d.illegal) begin
        illegal_ff <= 1'b1;
      end else if (wr_done && paddr_i == cpu8d_pkg::ADDR_STATUS && pwdata_i[8]) begin
        illegal_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= 32'h0000_0000;
    end else if (wr_done && paddr_i == cpu8d_pkg::ADDR_COUNT) begin
      count_ff <= 32'h0000_0000;
    end else if (accept) begin
      count_ff <= count_ff + 32'h0000_0001;
    end
  end

  // read data is captured in the setup cycle so the access needs no wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        cpu8d_pkg::ADDR_CTRL:   prdata_ff <= ctrl_ff;
        cpu8d_pkg::ADDR_STATUS: prdata_ff <= {23'h00_0000, illegal_ff, last_op_ff};
        cpu8d_pkg::ADDR_COUNT:  prdata_ff <= count_ff;
        default:                prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata_o  = prdata_ff;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence req_s(logic [7:0] op);
    accept && opcode_i == op;
  endsequence

  inherent_len_a: assert property (accept && opcode_i[7:4] == 4'h9 && !d.illegal
    |=> dec_valid_o && dec_o.length == 2'h1 && dec_o.cycles == 4'h2)   // [RL1]
    else $error("inherent op wrong length or cycles");
  immediate_ea_a: assert property (accept && opcode_i == 8'hA6
    |=> dec_o.effective_addr == $past(pc_i) + 16'h0001
        && dec_o.next_pc == $past(pc_i) + 16'h0002)   // [RL2]
    else $error("immediate address or pc wrong");
  direct_page_a: assert property (accept && opcode_i[7:4] == 4'hB
    |=> dec_o.effective_addr[15:8] == 8'h00
        && dec_o.effective_addr[7:0] == $past(operand1_i))   // [RL3]
    else $error("direct address not in page zero");
  higher_cond_a: assert property (req_s(8'h22)
    |=> dec_o.taken == !($past(flags_i.c) || $past(flags_i.z)))   // [RL4]
    else $error("higher branch condition wrong");
  carry_cond_a: assert property (req_s(8'h25) |=> dec_o.taken == $past(flags_i.c))   // [RL5]
    else $error("carry set branch condition wrong");
  rel_timing_a: assert property (accept && opcode_i[7:4] == 4'h2
    |=> dec_o.length == 2'h2 && dec_o.cycles == 4'h3 && dec_o.is_branch)   // [RL6]
    else $error("relative branch timing wrong");
  mask_cond_a: assert property (req_s(8'h2D) |=> dec_o.taken == $past(flags_i.i))   // [RL7]
    else $error("mask set branch condition wrong");
  pin_cond_a: assert property (req_s(8'h2F) |=> dec_o.taken == $past(irq_sync_ff))   // [RL8]
    else $error("line high branch condition wrong");
  sub_branch_a: assert property (req_s(8'hAD)
    |=> dec_o.taken && dec_o.cycles == 4'h6 && dec_o.length == 2'h2)   // [RL9]
    else $error("subroutine branch decode wrong");
  bit_test_a: assert property (accept && opcode_i[7:4] == 4'h0
    |=> dec_o.length == 2'h3 && dec_o.cycles == 4'h5
        && dec_o.taken == ($past(data_byte_i[opcode_i[3:1]]) != $past(opcode_i[0])))   // [RL10]
    else $error("bit test branch decode wrong");
  bit_setclr_a: assert property (accept && opcode_i[7:4] == 4'h1
    |=> dec_o.mem_write && dec_o.cycles == 4'h5
        && dec_o.result[dec_o.bit_n] == !$past(opcode_i[0]))   // [RL11]
    else $error("bit set or clear result wrong");
  rmw_incr_a: assert property (req_s(8'h4C)
    |=> dec_o.result == $past(data_byte_i) + 8'h01 && !dec_o.on_index)   // [RL12]
    else $error("increment result wrong");
  rmw_index_a: assert property (req_s(8'h6C)
    |=> dec_o.effective_addr == {8'h00, $past(index_i)} + {8'h00, $past(operand1_i)}
        && dec_o.cycles == 4'h6)   // [RL13]
    else $error("offset indexed modify decode wrong");
  test_timing_a: assert property (req_s(8'h3D)
    |=> dec_o.cycles == 4'h4 && dec_o.mem_read && !dec_o.mem_write)   // [RL14] [RL20]
    else $error("memory test timing or write wrong");
  flag_ops_a: assert property (req_s(8'h99) |=> dec_o.ctl_op == cpu8d_pkg::CTL_SETC)   // [RL15]
    else $error("set carry decode wrong");
  trap_cycles_a: assert property (req_s(8'h83) |=> dec_o.cycles == 4'hA)   // [RL16]
    else $error("trap cycle count wrong");
  copy_op_a: assert property (req_s(8'h97) |=> dec_o.ctl_op == cpu8d_pkg::CTL_A2X)   // [RL17]
    else $error("copy decode wrong");
  stop_op_a: assert property (req_s(8'h8E)
    |=> dec_o.ctl_op == cpu8d_pkg::CTL_STOP && dec_o.cycles == 4'h2)   // [RL18]
    else $error("stop decode wrong");
  branch_target_a: assert property (req_s(8'h20)
    |=> dec_o.next_pc == $past(pc_i) + 16'h0002
        + {{8{$past(operand1_i[7])}}, $past(operand1_i)})   // [RL19]
    else $error("branch target wrong");
endmodule
`default_nettype wire

/* File: cpu8d_mem_model.sv */
`default_nettype none
// -----------------------------------------------
// program and data memory on the cpu bus
// -----------------------------------------------
module cpu8d_mem_model (
  // fetch address
  input  wire logic [15:0] pc_i,
  // bytes toward the decoder
  output logic      [7:0]  opcode_o,
  output logic      [7:0]  operand1_o,
  output logic      [7:0]  operand2_o,
  output logic      [7:0]  data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] bytes [0:65535];
  assign opcode_o   = bytes[pc_i];
  assign operand1_o = bytes[pc_i + 16'h0001];
  assign operand2_o = bytes[pc_i + 16'h0002];
  // operand byte always from page zero, so register forms see it too
  assign data_o     = bytes[{8'h00, operand1_o}];
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, irq_line_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, dec_valid_i = 1'b0;
  logic        pready_o, pslverr_o, dec_valid_o, err, t;
  logic [7:0]  paddr_i = 8'h00, index_i = 8'h00, opcode_i, operand1_i, operand2_i;
  logic [7:0]  data_byte_i, op, a, b, d;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, r;
  logic [15:0] pc_i = 16'h0, pc;
  logic [3:0]  h;
  cpu8d_pkg::cpu8d_flags_t flags_i = '0;
  cpu8d_pkg::cpu8d_dec_t   dec_o;
  int          seed = 67, failures = 0, compares = 0, cnt = 0;
  logic [3:0]  lo [11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hF};
  logic [11:0] ctl_t [13] = '{12'h972, 12'h9F2, 12'h992, 12'h982, 12'h9B2, 12'h9A2,
    12'h9C2, 12'h9D2, 12'h8E2, 12'h8F2, 12'h83A, 12'h816, 12'h809};
  always #5 clk_i = ~clk_i;
  cpu8d_decode uut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .dec_valid_i, .opcode_i, .operand1_i, .operand2_i,
    .pc_i, .index_i, .data_byte_i, .flags_i, .irq_line_i, .dec_valid_o, .dec_o);
  cpu8d_mem_model mem (.pc_i, .opcode_o(opcode_i), .operand1_o(operand1_i),
    .operand2_o(operand2_i), .data_o(data_byte_i));
  // -----------------------------------------------
  // helpers
  // -----------------------------------------------
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n = 0;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= ad;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    rd  = prdata_o;
    err = pslverr_o;
    if (n == 16) begin
      failures++;
      stop_test();
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // fresh random fetch address, operands and flags; pc kept out of page zero
  task automatic roll;
    r  = $random(seed);
    pc = {2'b10, r[29:16]};
    a  = r[15:8];
    b  = r[7:0];
    d  = 8'($random(seed));
    flags_i    <= r[4:0];
    irq_line_i <= r[5];
  endtask
  task automatic dec(input logic [7:0] o, input logic ev);
    int n = 0;
    @(posedge clk_i);
    mem.bytes[pc]           <= o;
    mem.bytes[pc + 16'h1]   <= a;
    mem.bytes[pc + 16'h2]   <= b;
    mem.bytes[{8'h00, a}]   <= d;
    pc_i        <= pc;
    index_i     <= b;
    dec_valid_i <= 1'b1;
    @(posedge clk_i);
    dec_valid_i <= 1'b0;
    #1;
    while (dec_valid_o !== 1'b1 && n < 3) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(dec_valid_o, ev);
    if (ev) cnt++;
  endtask
  function automatic logic br_taken(input logic [7:0] o, input logic [4:0] f, input logic q);
    logic c;
    case (o[3:1])
      3'h0: c = 1'b1;
      3'h1: c = !(f[0] | f[1]);
      3'h2: c = !f[0];
      3'h3: c = !f[1];
      3'h4: c = !f[4];
      3'h5: c = !f[2];
      3'h6: c = !f[3];
      default: c = !q;
    endcase
    return c ^ o[0];
  endfunction
  function automatic logic [7:0] rmw_res(input logic [7:0] o, v, input logic c);
    case (o[3:0])
      4'h0: return 8'h00 - v;
      4'h3: return ~v;
      4'h4: return {1'b0, v[7:1]};
      4'h6: return {c, v[7:1]};
      4'h7: return {v[7], v[7:1]};
      4'h8: return {v[6:0], 1'b0};
      4'h9: return {v[6:0], c};
      4'hA: return v - 8'h01;
      4'hC: return v + 8'h01;
      default: return 8'h00;
    endcase
  endfunction
  // -----------------------------------------------
  // sequence
  // -----------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, cpu8d_pkg::ADDR_CTRL, 32'h0);
    chk(rd[15:0], 16'h0001);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 17; i++) begin
      roll();
      repeat (2) @(posedge clk_i);
      op = (i == 16) ? 8'hAD : 8'h20 + 8'(i);
      t  = (i == 16) || br_taken(op, flags_i, irq_line_i);
      dec(op, 1'b1);
      chk(dec_o.length, 2'h2);
      chk(dec_o.cycles, (i == 16) ? 4'h6 : 4'h3);
      chk(dec_o.taken, t);
      chk(dec_o.next_pc, pc + 16'h2 + (t ? {{8{a[7]}}, a} : 16'h0));
    end
    for (int k = 0; k < 32; k++) begin
      roll();
      op = {3'h0, k[1], k[4:2], k[0]};
      t  = d[k[4:2]] ^ k[0];
      dec(op, 1'b1);
      chk(dec_o.cycles, 4'h5);
      chk(dec_o.length, k[1] ? 2'h2 : 2'h3);
      if (k[1]) chk(dec_o.result, k[0] ? d & ~(8'h01 << k[4:2]) : d | (8'h01 << k[4:2]));
      else chk(dec_o.next_pc, pc + 16'h3 + (t ? {{8{b[7]}}, b} : 16'h0));
    end
    for (int k = 0; k < 55; k++) begin
      roll();
      h  = 4'(3 + k / 11);
      op = {h, lo[k % 11]};
      dec(op, 1'b1);
      chk(dec_o.length, (h == 4'h3 || h == 4'h6) ? 2'h2 : 2'h1);
      chk(dec_o.cycles, (h == 4'h6) ? 4'h6 - (op[3:0] == 4'hD) :
        (h < 4'h6 && h != 4'h3) ? 4'h3 : 4'h5 - (op[3:0] == 4'hD));
      chk(dec_o.mem_write, h != 4'h4 && h != 4'h5 && op[3:0] != 4'hD);
      if (op[3:0] != 4'hD) chk(dec_o.result, rmw_res(op, d, flags_i.c));
      if (h == 4'h3) chk(dec_o.effective_addr, {8'h00, a});
    end
    for (int k = 0; k < 13; k++) begin
      roll();
      dec(ctl_t[k][11:4], 1'b1);
      chk(dec_o.length, 2'h1);
      chk(dec_o.cycles, ctl_t[k][3:0]);
      chk(dec_o.mode, cpu8d_pkg::MODE_INH);
    end
    roll();
    dec(8'hA6, 1'b1);
    chk(dec_o.effective_addr, pc + 16'h1);
    chk(dec_o.next_pc, pc + 16'h2);
    apb(1'b0, cpu8d_pkg::ADDR_COUNT, 32'h0);
    chk(rd[15:0], 16'(cnt));
    apb(1'b1, cpu8d_pkg::ADDR_CTRL, 32'h0);
    dec(8'h9D, 1'b0);
    apb(1'b0, cpu8d_pkg::ADDR_STATUS, 32'h0);
    chk(rd[15:0], 16'h00A6);
    stop_test();
  end
  // hang guard, well past the few hundred cycles the sequence needs
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
